//--- asf_ahb_slave.sv
// ahb-lite slave front end; writes land in the data phase, reads take
// one wait state so that hrdata comes from a flip-flop
// assumes hready is this slave's own hreadyout
`timescale 1ns/1ns
`include "asf_regs.svh"

module asf_ahb_slave (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [31:0] hrdata,
    asf_reg_if.slave         bus
);
    logic                   dp_wr;
    logic                   dp_rd;
    logic [`ASF_ADDR_W-1:0] dp_addr;
    logic                   addr_ph;

    // only nonseq or seq with the bus ready start a transfer
    assign addr_ph = hsel & htrans[1] & hready;

    // data phase bookkeeping, read wait state; response stays okay
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_wr     <= 1'b0;
            dp_rd     <= 1'b0;
            dp_addr   <= '0;
            hreadyout <= 1'b1;
            hrdata    <= 32'h0000_0000;
            hresp     <= 1'b0;
        end else if (dp_rd) begin
            dp_rd     <= 1'b0;
            hreadyout <= 1'b1;
            hrdata    <= bus.rdata;   // unmapped reads give zero
        end else begin
            dp_wr <= addr_ph & hwrite;
            dp_rd <= addr_ph & ~hwrite;
            if (addr_ph) begin
                dp_addr   <= haddr[`ASF_ADDR_W-1:0];
                hreadyout <= hwrite;
            end
        end
    end

    assign bus.wr    = dp_wr;
    assign bus.addr  = dp_addr;
    assign bus.wdata = hwdata;
endmodule

//--- asf_conv_model.sv
// converter model on the far side of the flow control
// assumes start_conv and abort_seq are one-cycle pulses on hclk
`timescale 1ns/1ns

module asf_conv_model #(
    parameter int LEN   = 6,
    parameter int CONVS = 3
) (
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic start_conv,
    input  wire logic abort_seq,
    output logic      conv_boundary,
    output logic      result_stored,
    output logic      eol_exec,
    output logic      eol_pending
);
    logic busy;
    int   cnt;
    int   n;

    // runs CONVS conversions of LEN cycles, stops on abort
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            busy <= 1'b0;
            cnt <= 0;
            n <= 0;
            conv_boundary <= 1'b0;
            result_stored <= 1'b0;
            eol_exec <= 1'b0;
        end else begin
            conv_boundary <= 1'b0;
            result_stored <= 1'b0;
            eol_exec <= 1'b0;
            if (start_conv) begin
                busy <= 1'b1;
                cnt <= 0;
                n <= 0;
            end else if (abort_seq) begin
                busy <= 1'b0;
            end else if (busy && cnt == LEN - 1) begin
                cnt <= 0;
                n <= n + 1;
                conv_boundary <= 1'b1;
                result_stored <= 1'b1;
                eol_exec <= (n == CONVS - 1);
                busy <= (n != CONVS - 1);
            end else if (busy) begin
                cnt <= cnt + 1;
            end
        end
    end

    // last conversion of the list is running
    assign eol_pending = busy && (n == CONVS - 1);
endmodule

//--- asf_edge.sv
// rising edge detector for internal request lines on the module clock
// assumes inputs are already synchronous to hclk
`timescale 1ns/1ns

module asf_edge #(
    parameter int W = 3
) (
    input  wire logic         hclk,
    input  wire logic         hresetn,
    input  wire logic [W-1:0] level,
    output logic      [W-1:0] rise
);
    logic [W-1:0] prev;

    // remember last level of each line
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prev <= '0;
        end else begin
            prev <= level;
        end
    end

    assign rise = level & ~prev;
endmodule

//--- asf_flow_ctrl.sv
// Functional notes
// - restart before swap-ready: restart same list
// - restart with swap-ready, double buffer: switch list
// - abort stops at next conversion boundary
// - abort from line rising edge or write
// - abort bit self-clears once abort completed
// - result list not done without end/abort
// - abort accepted at any moment, any mode
// - trigger before restart: error, block till reset
// - restart bit self-clears after restart executes
// - after restart, triggers accepted from list top
// - restart after abort only restarts
// - unexpected restart sets abort automatically
// - automatic abort raises restart error flag
//
// top of the converter sequencer flow control with its register file
// assumes request lines and converter indications share hclk
`timescale 1ns/1ns
`include "asf_regs.svh"

module asf_flow_ctrl
    import asf_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [31:0] hrdata,
    input  wire logic        restart_req,
    input  wire logic        abort_req,
    input  wire logic        trigger_req,
    input  wire logic        list_swap_ready,
    input  wire logic        conv_boundary,
    input  wire logic        result_stored,
    input  wire logic        eol_exec,
    input  wire logic        eol_pending,
    output logic             start_conv,
    output logic             start_from_top,
    output logic             active_list,
    output logic             abort_seq,
    output logic             irq
);
    asf_reg_if bus ();

    logic [2:0]            rise;
    logic                  abort_ctrl_bit;
    logic                  restart_ctrl_bit;
    logic                  trigger_ctrl_bit;
    logic                  trigger_error_flag;
    logic                  restart_error_flag;
    logic                  rvl_done;
    logic                  abort_done;
    logic                  switch_list;
    logic [7:0]            ctrl;
    logic [`ASF_IRQ_W-1:0] int_stat;
    logic [`ASF_IRQ_W-1:0] int_en;
    logic [`ASF_IRQ_W-1:0] events;
    asf_state_t            state;
    asf_mode_t             mode;
    logic                  ctrl_wr;
    logic                  soft_rst;
    logic                  sw_abort;
    logic                  sw_restart;
    logic                  sw_trigger;
    logic                  abort_new;
    logic                  restart_new;
    logic                  trigger_new;
    logic                  abort_exec;
    logic                  restart_exec;
    logic                  auto_abort;
    logic                  trigger_ctrl_bit_err;
    logic                  trigger_ctrl_bit_ok;

    // true when a register write hits the given offset
    function automatic logic hit(input logic [`ASF_ADDR_W-1:0] ofs);
        hit = bus.wr && (bus.addr == ofs);
    endfunction

    asf_ahb_slave u_slave (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hwdata    (hwdata),
        .hready    (hready),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .hrdata    (hrdata),
        .bus       (bus)
    );

    // edges of the internal abort, restart and trigger lines
    asf_edge #(.W(3)) u_edge (
        .hclk    (hclk),
        .hresetn (hresetn),
        .level   ({trigger_req, restart_req, abort_req}),
        .rise    (rise)
    );

    // software decodes of the control register
    assign ctrl_wr    = hit(`ASF_OFS_CTRL);
    assign soft_rst   = ctrl_wr & bus.wdata[`ASF_CTRL_SOFT_RST];
    assign sw_abort   = ctrl_wr & bus.wdata[`ASF_CTRL_ABORT];
    assign sw_restart = ctrl_wr & bus.wdata[`ASF_CTRL_RESTART];
    assign sw_trigger = ctrl_wr & bus.wdata[`ASF_CTRL_TRIGGER];
    assign mode       = asf_mode_t'(ctrl[`ASF_CTRL_MODE]);

    // abort request from line edge or write, accepted at any time
    assign abort_new   = rise[0] | sw_abort;
    assign restart_new = rise[1] | sw_restart;
    assign trigger_new = rise[2] | sw_trigger;
    // unexpected restart: no end of list or abort done or coming
    assign auto_abort = restart_new & ~rvl_done & ~eol_pending
                      & ~eol_exec & ~abort_ctrl_bit & ~abort_new;
    // abort takes effect at a boundary, or at once when nothing runs
    assign abort_exec = abort_ctrl_bit
                      & ((state != ASF_RUN) | conv_boundary | result_stored);
    // restart runs alone once no abort is outstanding
    assign restart_exec = restart_ctrl_bit & ~abort_ctrl_bit
                        & ~abort_new & ~auto_abort;
    // trigger after abort but before restart in restart mode
    assign trigger_ctrl_bit_err = trigger_new & (mode == ASF_MODE_RESTART)
                    & abort_done & ~restart_exec & (state != ASF_BLOCKED);
    assign trigger_ctrl_bit_ok  = trigger_new & ~trigger_ctrl_bit_err & (state == ASF_IDLE)
                    & ~abort_ctrl_bit & ~abort_new & ~restart_ctrl_bit;

    // software mode bits; command bits are not stored here
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl <= `ASF_CTRL_RST;
        end else if (ctrl_wr) begin
            ctrl <= {1'b0, 1'b0, bus.wdata[`ASF_CTRL_DBUF],
                     bus.wdata[`ASF_CTRL_MODE], 4'h0};
        end
    end

    // sequencer state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= ASF_IDLE;
        end else if (soft_rst) begin
            state <= ASF_IDLE;
        end else begin
            unique case (state)
                ASF_IDLE: begin
                    if (trigger_ctrl_bit_err) begin
                        state <= ASF_BLOCKED;
                    end else if (trigger_ctrl_bit_ok) begin
                        state <= ASF_RUN;
                    end
                end
                ASF_RUN: begin
                    if (abort_exec || eol_exec) begin
                        state <= ASF_IDLE;
                    end
                end
                ASF_BLOCKED: begin
                    state <= ASF_BLOCKED;
                end
                default: begin
                    state <= ASF_IDLE;
                end
            endcase
        end
    end

    // abort control bit: set wins over the self-clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            abort_ctrl_bit <= 1'b0;
        end else if (soft_rst) begin
            abort_ctrl_bit <= 1'b0;
        end else if (abort_new || auto_abort) begin
            abort_ctrl_bit <= 1'b1;
        end else if (abort_exec) begin
            abort_ctrl_bit <= 1'b0;
        end
    end

    // result list done at reset or soft reset and after end of list or executed abort
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rvl_done <= 1'b1;
        end else if (soft_rst) begin
            rvl_done <= 1'b1;
        end else if (abort_exec || eol_exec) begin
            rvl_done <= 1'b1;
        end else if (trigger_ctrl_bit_ok) begin
            rvl_done <= 1'b0;
        end
    end

    // executed abort stays remembered until a restart runs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            abort_done <= 1'b0;
        end else if (soft_rst) begin
            abort_done <= 1'b0;
        end else if (abort_exec) begin
            abort_done <= 1'b1;
        end else if (restart_exec) begin
            abort_done <= 1'b0;
        end
    end

    // restart control bit, list choice caught at request time
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            restart_ctrl_bit <= 1'b0;
            switch_list      <= 1'b0;
        end else if (soft_rst) begin
            restart_ctrl_bit <= 1'b0;
            switch_list      <= 1'b0;
        end else if (restart_new) begin
            restart_ctrl_bit <= 1'b1;
            switch_list      <= list_swap_ready
                              & ctrl[`ASF_CTRL_DBUF];
        end else if (restart_exec) begin
            restart_ctrl_bit <= 1'b0;
            switch_list      <= 1'b0;
        end
    end

    // active list and restart-from-top marker
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            active_list    <= 1'b0;
            start_from_top <= 1'b0;
        end else if (soft_rst) begin
            active_list    <= 1'b0;
            start_from_top <= 1'b0;
        end else if (restart_exec) begin
            active_list    <= active_list ^ switch_list;
            start_from_top <= 1'b1;
        end else if (trigger_ctrl_bit_ok) begin
            start_from_top <= 1'b0;
        end
    end

    // trigger control bit; stays set while blocked
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            trigger_ctrl_bit <= 1'b0;
        end else if (soft_rst) begin
            trigger_ctrl_bit <= 1'b0;
        end else if (trigger_ctrl_bit_ok || trigger_ctrl_bit_err) begin
            trigger_ctrl_bit <= 1'b1;
        end else if (state == ASF_RUN && (abort_exec || eol_exec)) begin
            trigger_ctrl_bit <= 1'b0;
        end
    end

    // error flags are the sticky interrupt status bits
    assign trigger_error_flag = int_stat[`ASF_IRQ_TRIGGER_CTRL_BIT_ERR];
    assign restart_error_flag = int_stat[`ASF_IRQ_RESTART_CTRL_BIT_ERR];

    // converter command pulses
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            start_conv <= 1'b0;
            abort_seq  <= 1'b0;
        end else begin
            start_conv <= trigger_ctrl_bit_ok & ~soft_rst;
            abort_seq  <= abort_exec & ~soft_rst;
        end
    end

    // interrupt events; set wins over a same-cycle clear
    assign events = {eol_exec & (state == ASF_RUN), restart_exec,
                     abort_exec, auto_abort, trigger_ctrl_bit_err};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            int_stat <= `ASF_IRQ_RST;
        end else if (soft_rst) begin
            int_stat <= `ASF_IRQ_RST;
        end else if (hit(`ASF_OFS_INT_CLR)) begin
            int_stat <= (int_stat & ~bus.wdata[`ASF_IRQ_W-1:0]) | events;
        end else begin
            int_stat <= int_stat | events;
        end
    end

    // interrupt enables
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            int_en <= `ASF_IRQ_RST;
        end else if (hit(`ASF_OFS_INT_EN)) begin
            int_en <= bus.wdata[`ASF_IRQ_W-1:0];
        end
    end

    // level interrupt while an enabled status bit is set
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(int_stat & int_en);
        end
    end

    // read decode; unmapped offsets read zero
    always_comb begin
        bus.rdata = 32'h0000_0000;
        case (bus.addr)
            `ASF_OFS_CTRL: begin
                bus.rdata[7:0] = ctrl | {5'h00, trigger_ctrl_bit,
                                         restart_ctrl_bit, abort_ctrl_bit};
            end
            `ASF_OFS_STATUS: begin
                bus.rdata[7:0] = {abort_done, active_list,
                                  state == ASF_BLOCKED, rvl_done,
                                  state == ASF_RUN, trigger_ctrl_bit,
                                  restart_ctrl_bit, abort_ctrl_bit};
            end
            `ASF_OFS_INT_STAT: begin
                bus.rdata[`ASF_IRQ_W-1:0] = int_stat;
            end
            `ASF_OFS_INT_EN: begin
                bus.rdata[`ASF_IRQ_W-1:0] = int_en;
            end
        endcase
    end
endmodule

//--- asf_flow_ctrl_props.sv
// port checks of the flow control
// assumes it is bound to asf_flow_ctrl, one clock domain
`timescale 1ns/1ns

module asf_flow_ctrl_props (
    input wire logic       hclk,
    input wire logic       hresetn,
    input wire logic       hsel,
    input wire logic [1:0] htrans,
    input wire logic       hwrite,
    input wire logic       hready,
    input wire logic       abort_req,
    input wire logic       restart_req,
    input wire logic       start_conv,
    input wire logic       start_from_top,
    input wire logic       active_list,
    input wire logic       abort_seq,
    input wire logic       irq
);
    logic [3:0] wr_hist;
    logic       done_q;

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    // recent bus writes, the only legal cause of irq falling
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) wr_hist <= 4'h0;
        else wr_hist <= {wr_hist[2:0], hsel & htrans[1] & hready & hwrite};
    end

    // abort executed and no run or abort line request since
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) done_q <= 1'b0;
        else if (abort_seq) done_q <= 1'b1;
        else if (start_conv | abort_req) done_q <= 1'b0;
    end

    property p_abort_pulse;
        abort_seq |=> !abort_seq;
    endproperty
    a_abort_pulse: assert property (p_abort_pulse)
        else $error("abort pulse longer than one cycle");

    property p_start_pulse;
        start_conv |=> !start_conv;
    endproperty
    a_start_pulse: assert property (p_start_pulse)
        else $error("start pulse longer than one cycle");

    property p_abort_done;
        $rose(abort_req) |-> ##[2:40] abort_seq;
    endproperty
    a_abort_done: assert property (p_abort_done)
        else $error("abort line edge not executed");

    property p_excl;
        abort_seq |-> !start_conv;
    endproperty
    a_excl: assert property (p_excl)
        else $error("start together with abort");

    property p_start_top;
        start_conv |-> ##[0:1] !start_from_top;
    endproperty
    a_start_top: assert property (p_start_top)
        else $error("top flag kept after start");

    property p_list_top;
        $rose(active_list) |-> ##[0:1] start_from_top;
    endproperty
    a_list_top: assert property (p_list_top)
        else $error("list switched without start from top");

    property p_irq_fall;
        $fell(irq) |-> wr_hist != 4'h0;
    endproperty
    a_irq_fall: assert property (p_irq_fall)
        else $error("irq fell without a bus write");

    property p_restart_only;
        done_q && $rose(restart_req) |-> ##1 !abort_seq [*8];
    endproperty
    a_restart_only: assert property (p_restart_only)
        else $error("restart after abort aborted again");
endmodule

bind asf_flow_ctrl asf_flow_ctrl_props asf_flow_ctrl_props_i (
    .hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .abort_req,
    .restart_req, .start_conv, .start_from_top, .active_list,
    .abort_seq, .irq
);

//--- asf_pkg.sv
// types shared by the flow control modules
// assumes asf_regs.svh holds the numeric constants
package asf_pkg;

    // flow control modes selected by software
    typedef enum logic {
        ASF_MODE_TRIGGER = 1'b0,
        ASF_MODE_RESTART = 1'b1
    } asf_mode_t;

    // sequencer state seen by the flow control
    typedef enum logic [1:0] {
        ASF_IDLE    = 2'b00,
        ASF_RUN     = 2'b01,
        ASF_BLOCKED = 2'b10
    } asf_state_t;

endpackage

//--- asf_reg_if.sv
// simple register port between the bus slave and the flow control
// assumes one clock; strobes are single-cycle
`timescale 1ns/1ns
`include "asf_regs.svh"

interface asf_reg_if;
    logic                   wr;
    logic [`ASF_ADDR_W-1:0] addr;
    logic [31:0]            wdata;
    logic [31:0]            rdata;

    modport slave  (output wr, output addr, output wdata,
                    input rdata);
    modport target (input wr, input addr, input wdata,
                    output rdata);
endinterface

//--- asf_regs.svh
// register offsets, field positions, reset values of the flow control
// assumes byte addresses on a 32-bit bus, one register per aligned word
`ifndef ASF_REGS_SVH
`define ASF_REGS_SVH

`define ASF_ADDR_W          8
`define ASF_OFS_CTRL        8'h00
`define ASF_OFS_STATUS      8'h04
`define ASF_OFS_INT_STAT    8'h08
`define ASF_OFS_INT_CLR     8'h0c
`define ASF_OFS_INT_EN      8'h10

// control register fields
`define ASF_CTRL_ABORT      0
`define ASF_CTRL_RESTART    1
`define ASF_CTRL_TRIGGER    2
`define ASF_CTRL_MODE       4
`define ASF_CTRL_DBUF       5
`define ASF_CTRL_SOFT_RST   7
`define ASF_CTRL_RST        8'h00

// status register fields
`define ASF_ST_ABORT        0
`define ASF_ST_RESTART      1
`define ASF_ST_TRIGGER      2
`define ASF_ST_RUNNING      3
`define ASF_ST_RVL_DONE     4
`define ASF_ST_BLOCKED      5
`define ASF_ST_LIST         6
`define ASF_ST_ABORT_DONE   7

// interrupt status, clear and enable fields
`define ASF_IRQ_W           5
`define ASF_IRQ_TRIGGER_CTRL_BIT_ERR    0
`define ASF_IRQ_RESTART_CTRL_BIT_ERR    1
`define ASF_IRQ_ABORT_DONE  2
`define ASF_IRQ_RESTART_CTRL_BIT_DONE   3
`define ASF_IRQ_END_LIST    4
`define ASF_IRQ_RST         5'h00

`endif

//--- tb_adc_sequence_flow_control.sv
// self-checking bench of the flow control with a converter model
// assumes asf_regs.svh offsets and a single 125 MHz clock
`timescale 1ns/1ns
`include "asf_regs.svh"

module tb_adc_sequence_flow_control;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic        hready;
    logic        hreadyout, hresp;
    logic [31:0] hrdata;
    logic        restart_req = 1'b0;
    logic        abort_req = 1'b0;
    logic        trigger_req = 1'b0;
    logic        list_swap_ready = 1'b0;
    logic        conv_boundary, result_stored, eol_exec, eol_pending;
    logic        start_conv, start_from_top, active_list, abort_seq, irq;
    int          errors = 0;
    int          tests_run = 0;

    assign hready = hreadyout;

    asf_flow_ctrl asf_flow_ctrl_i (.hclk, .hresetn, .hsel, .haddr,
        .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp,
        .hrdata, .restart_req, .abort_req, .trigger_req, .list_swap_ready,
        .conv_boundary, .result_stored, .eol_exec, .eol_pending,
        .start_conv, .start_from_top, .active_list, .abort_seq, .irq);

    asf_conv_model #(.LEN(6), .CONVS(3)) asf_conv_model_i (.hclk,
        .hresetn, .start_conv, .abort_seq, .conv_boundary, .result_stored,
        .eol_exec, .eol_pending);

    // 8 ns clock
    initial begin
        forever #4 hclk = ~hclk;
    end

    task automatic wrap_up;
        if (errors == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: %h not %h", $time, seen, exp);
        end
    endtask

    // waits for hready high at an edge, bounded
    task automatic hold_ready;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) begin
            errors++;
            wrap_up();
        end
    endtask

    // one single ahb-lite word transfer
    task automatic ahb(input logic w, input logic [31:0] a, d,
                       output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= w;
        hold_ready();
        htrans <= 2'b00;
        hwdata <= d;
        hold_ready();
        r = hrdata;
        hsel <= 1'b0;
    endtask

    task automatic wr(input logic [31:0] a, d);
        logic [31:0] r;
        ahb(1'b1, a, d, r);
    endtask

    task automatic chk(input logic [31:0] a, m, exp);
        logic [31:0] r;
        ahb(1'b0, a, 32'h0, r);
        check(r & m, exp);
    endtask

    // one-cycle high on trigger, abort or restart line
    task automatic pulse(input int k);
        @(posedge hclk);
        case (k)
            0: trigger_req <= 1'b1;
            1: abort_req <= 1'b1;
            default: restart_req <= 1'b1;
        endcase
        @(posedge hclk);
        trigger_req <= 1'b0;
        abort_req <= 1'b0;
        restart_req <= 1'b0;
    endtask

    // waits for start, abort executed or end of list
    task automatic wait_for(input int k);
        int   n;
        logic s;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
            s = (k == 0) ? start_conv : (k == 1) ? abort_seq : eol_exec;
        end while (s !== 1'b1 && n < 100);
        if (s !== 1'b1) begin
            errors++;
            wrap_up();
        end
    endtask

    task automatic no_start;
        int c;
        c = 0;
        repeat (10) begin
            @(posedge hclk);
            if (start_conv === 1'b1) c++;
        end
        check(c, 0);
    endtask

    task automatic s_reset;
        chk(`ASF_OFS_CTRL, 32'hffffffff, 32'h0);
        chk(`ASF_OFS_STATUS, 32'hff, 32'h10);
        chk(`ASF_OFS_INT_STAT, 32'hffffffff, 32'h0);
        chk(32'h40, 32'hffffffff, 32'h0);
        wr(`ASF_OFS_INT_EN, 32'h1f);
    endtask

    task automatic s_run_eol;
        wr(`ASF_OFS_CTRL, 32'h0);
        pulse(0);
        wait_for(0);
        chk(`ASF_OFS_STATUS, 32'h18, 32'h8);
        wait_for(2);
        chk(`ASF_OFS_STATUS, 32'h18, 32'h10);
        chk(`ASF_OFS_INT_STAT, 32'h10, 32'h10);
        check(irq, 1'b1);
        wr(`ASF_OFS_INT_CLR, 32'h1f);
        repeat (2) @(posedge hclk);
        check(irq, 1'b0);
    endtask

    task automatic s_abort_line;
        pulse(0);
        wait_for(0);
        pulse(1);
        wait_for(1);
        chk(`ASF_OFS_STATUS, 32'h19, 32'h10);
        chk(`ASF_OFS_INT_STAT, 32'h4, 32'h4);
        wr(`ASF_OFS_INT_CLR, 32'h1f);
    endtask

    // software abort with interrupts masked
    task automatic s_abort_write;
        wr(`ASF_OFS_INT_EN, 32'h0);
        pulse(0);
        wait_for(0);
        wr(`ASF_OFS_CTRL, 32'h1);
        wait_for(1);
        chk(`ASF_OFS_INT_STAT, 32'h4, 32'h4);
        check(irq, 1'b0);
        wr(`ASF_OFS_INT_EN, 32'h1f);
        repeat (2) @(posedge hclk);
        check(irq, 1'b1);
        wr(`ASF_OFS_INT_CLR, 32'h1f);
    endtask

    task automatic s_unexp_restart;
        pulse(0);
        wait_for(0);
        pulse(2);
        wait_for(1);
        chk(`ASF_OFS_INT_STAT, 32'h2, 32'h2);
        repeat (4) @(posedge hclk);
        check(start_from_top, 1'b1);
        wr(`ASF_OFS_INT_CLR, 32'h1f);
    endtask

    task automatic s_restart_mode;
        wr(`ASF_OFS_CTRL, 32'h10);
        pulse(0);
        wait_for(0);
        pulse(1);
        wait_for(1);
        pulse(2);
        repeat (6) @(posedge hclk);
        chk(`ASF_OFS_INT_STAT, 32'ha, 32'h8);
        chk(`ASF_OFS_STATUS, 32'h2, 32'h0);
        pulse(0);
        wait_for(0);
        chk(`ASF_OFS_STATUS, 32'h8, 32'h8);
        pulse(1);
        wait_for(1);
        pulse(0);
        repeat (3) @(posedge hclk);
        chk(`ASF_OFS_INT_STAT, 32'h1, 32'h1);
        chk(`ASF_OFS_STATUS, 32'h24, 32'h24);
        pulse(0);
        no_start();
        wr(`ASF_OFS_CTRL, 32'h90);
        chk(`ASF_OFS_INT_STAT, 32'h1f, 32'h0);
        chk(`ASF_OFS_STATUS, 32'h20, 32'h0);
    endtask

    task automatic s_list;
        wr(`ASF_OFS_CTRL, 32'h20);
        list_swap_ready <= 1'b1;
        pulse(2);
        repeat (4) @(posedge hclk);
        check(active_list, 1'b1);
        list_swap_ready <= 1'b0;
        pulse(2);
        repeat (4) @(posedge hclk);
        check(active_list, 1'b1);
        check(start_from_top, 1'b1);
        pulse(0);
        wait_for(0);
        wait_for(2);
    endtask

    // reset, then every scenario in turn
    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        s_reset();
        s_run_eol();
        s_abort_line();
        s_abort_write();
        s_unexp_restart();
        s_restart_mode();
        s_list();
        wrap_up();
    end
endmodule
